// [ccrb_map.svh]
// offsets, field positions, reset values and sizes of the codec control bank
`ifndef CCRB_MAP_SVH
`define CCRB_MAP_SVH
`define CCRB_ADDR_BURST 5'h03
`define CCRB_ADDR_BB_CTRL 5'h06
`define CCRB_ADDR_VOICE1 5'h08
`define CCRB_ADDR_POP 5'h0a
`define CCRB_ADDR_VOICE2 5'h0b
`define CCRB_ADDR_GAIN_CAL 5'h0e
`define CCRB_PAGE_ZERO 1'b0
`define CCRB_PAGE_ONE 1'b1
`define CCRB_RESET_VALUE 10'h000
`define CCRB_WORD_W 10
`define CCRB_BURST_BITS 160
`define CCRB_BURST_WORDS 16
`define CCRB_LAST_BIT 8'h9f
`define CCRB_FIFO_DEPTH 32
`define CCRB_BB_EXT_CAL 9
`define CCRB_BB_LEVEL_LO 6
`define CCRB_BB_MULTISLOT 5
`define CCRB_BB_MOD_TYPE 4
`define CCRB_BB_LOOPBACK 3
`define CCRB_BB_CM_LO 0
`define CCRB_V1_BYPASS 9
`define CCRB_V1_AUX_GAIN 8
`define CCRB_V1_SYNC 7
`define CCRB_V1_CLK_MODE 6
`define CCRB_V1_LOOPBACK 5
`define CCRB_V1_MIC_BIAS 4
`define CCRB_V1_UL_SELECT 3
`define CCRB_V1_BUZZER 2
`define CCRB_V1_EAR_EN 1
`define CCRB_V1_AUX_EN 0
`define CCRB_V2_HS_MIC 2
`define CCRB_V2_HSO_EN 1
`define CCRB_V2_HS_BIAS 0
`define CCRB_POP_DIS 0
`define CCRB_POP_CHG 1
`define CCRB_POP_AUTO 2
`endif

// [ccrb_pkg.sv]
// types and decode functions of the codec control bank
`default_nettype none
`include "ccrb_map.svh"
package ccrb_pkg;
  typedef enum logic [0:0] {
    CCRB_IDLE = 1'b0,
    CCRB_SEND = 1'b1
  } ccrb_tx_state_type;

  typedef struct packed {
    logic [1:0][`CCRB_BURST_BITS-1:0] buf_bits;
    logic [4:0] wr_ptr;
    ccrb_tx_state_type tx_state;
    logic [7:0] tx_cnt;
    logic tx_sel;
    logic alt_sel;
    logic tx_bit;
    logic tx_valid;
    logic [9:0] bb_ctrl;
    logic [3:0] i_gain;
    logic [9:0] voice1;
    logic [2:0] voice2;
    logic [8:0] pop;
    logic dl_on_d;
    logic [2:0] sync;
    logic vrst_lvl;
    logic vrst_pulse;
    logic [9:0] rdata;
  } ccrb_state_type;

  // output level code to index 0..5, lsb ignored above 011
  function automatic logic [2:0] ccrb_level_index(input logic [2:0] code);
    ccrb_level_index = code[2] ? {2'b10, code[1]} : code;
  endfunction

  // common-mode code to index 0..4, 1xx all one value
  function automatic logic [2:0] ccrb_cm_index(input logic [2:0] code);
    ccrb_cm_index = code[2] ? 3'h4 : code;
  endfunction
endpackage
`default_nettype wire

// [ccrb_top.sv]
// codec control register bank with uplink burst buffers and voice control
`timescale 1ns/1ps
`default_nettype none

module ccrb_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 32
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } ccrb_fifo_state_type;
  ccrb_fifo_state_type f_reg;
  ccrb_fifo_state_type f_next;
  logic push;
  logic pop;

  assign in_ready = f_reg.cnt != (AW+1)'(DEPTH);
  assign out_valid = f_reg.cnt != '0;
  assign out_data = f_reg.mem[f_reg.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    f_next = f_reg;
    if (push)
    begin
      f_next.mem[f_reg.wp] = in_data;
      f_next.wp = (f_reg.wp == AW'(DEPTH - 1)) ? '0 : f_reg.wp + 1'b1;
    end
    if (pop)
      f_next.rp = (f_reg.rp == AW'(DEPTH - 1)) ? '0 : f_reg.rp + 1'b1;
    f_next.cnt = f_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (reset)
    begin
      f_next.wp = '0;
      f_next.rp = '0;
      f_next.cnt = '0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset || ce)
      f_reg <= f_next;
  end
endmodule // ccrb_fifo

// Behaviour
// - burst is 160 bits in 16 ten-bit words: guard, tail, data, training, data, tail, guard
// - burst bits go out from bit zero upward through all 160
// - burst buffers keep contents through reset and after transmission
// - single slot sends buffer one only; multislot alternates buffer zero and one
// - modulation type bit clear selects GMSK
// - baseband loopback bit routes uplink I/Q back to downlink inputs
// - calibration select: zero automatic, one external
// - output level field picks six levels; 10x and 11x ignore the lsb
// - common-mode field: half supply or four voltages; 1xx all one value
// - I gain field is signed: 0000 none, upward raises, 1111 downward lowers
// - voice bypass skips voice filter, gain stage and volume control
// - aux input gain bit: zero low gain, one high gain
// - with sync enabled the voice reset pin resets voice logic and clears enable
// - voice clock mode: zero burst, one continuous
// - voice loopback feeds voice output samples into audio converter input
// - uplink select: zero aux input, one microphone only with uplink power on
// - buzzer bit powers down aux and ear stages regardless of enables
// - ear, aux and headset enables act only with downlink power on
// - second voice register bit 2 picks headset mic, bit 0 headset bias
// - mic bias bit: zero lower voltage, one higher voltage
// - auto mode: charge sets on downlink power rise, clears on enable, writes ignored
// - discharge inert while charge set, downlink power off or output enabled
module ccrb_top #(
  parameter int FIFO_DEPTH = `CCRB_FIFO_DEPTH
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  // register port
  input wire logic reg_page,
  input wire logic [4:0] reg_addr,
  input wire logic [9:0] reg_wdata,
  input wire logic reg_wr,
  output logic reg_wr_ready,
  input wire logic reg_rd,
  output logic [9:0] reg_rdata,
  // power state from the power-down register
  input wire logic voice_downlink_power_on,
  input wire logic voice_uplink_power_on,
  // burst stream
  input wire logic burst_start,
  output logic tx_bit,
  output logic tx_valid,
  output logic tx_busy,
  // baseband controls
  output logic gmsk_mode,
  output logic baseband_loopback,
  output logic calibration_select,
  output logic [2:0] output_level_index,
  output logic [2:0] common_mode_index,
  output logic signed [3:0] i_gain_calibration,
  // voice controls
  output logic voice_bypass,
  output logic aux_input_gain_high,
  output logic voice_clock_continuous,
  output logic voice_loopback,
  output logic mic_bias_high,
  output logic microphone_input_selected,
  output logic ear_amp_on,
  output logic aux_amp_on,
  output logic headset_amp_on,
  output logic headset_mic_select,
  output logic headset_bias_select,
  output logic [2:0] capacitor_charge_on,
  output logic [2:0] capacitor_discharge_on,
  // external voice reset
  input wire logic voice_reset_pin,
  output logic voice_digital_reset
);
  import ccrb_pkg::*;

  ccrb_state_type s_reg;
  ccrb_state_type s_next;
  logic burst_hit;
  logic wr_fire;
  logic start_ok;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [9:0] fifo_out_data;
  logic pop_fire;
  logic multislot;
  logic dl_rise;
  logic vrst_rise;
  logic [2:0] out_en;

  assign burst_hit = reg_page == `CCRB_PAGE_ZERO && reg_addr == `CCRB_ADDR_BURST;
  assign reg_wr_ready = burst_hit ? fifo_in_ready : 1'b1;
  assign wr_fire = reg_wr && reg_wr_ready;
  assign multislot = s_reg.bb_ctrl[`CCRB_BB_MULTISLOT];
  assign start_ok = burst_start && s_reg.tx_state == CCRB_IDLE;
  // buffer is never rewritten while it is being sent
  assign fifo_out_ready = s_reg.tx_state == CCRB_IDLE && !burst_start;
  assign pop_fire = fifo_out_valid && fifo_out_ready;
  assign dl_rise = voice_downlink_power_on && !s_reg.dl_on_d;
  assign vrst_rise = s_reg.sync[1] == s_reg.sync[2] && s_reg.sync[2] && !s_reg.vrst_lvl;
  // index 0 headset, 1 ear, 2 aux
  assign out_en = {s_reg.voice1[`CCRB_V1_AUX_EN], s_reg.voice1[`CCRB_V1_EAR_EN],
    s_reg.voice2[`CCRB_V2_HSO_EN]};

  ccrb_fifo #(
    .WIDTH(`CCRB_WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .reset(reset),
    .ce(ce),
    .in_valid(reg_wr && burst_hit),
    .in_ready(fifo_in_ready),
    .in_data(reg_wdata),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  always_comb
  begin
    logic [1:0][`CCRB_BURST_BITS-1:0] keep;
    logic wsel;
    logic [7:0] base;
    keep = s_reg.buf_bits;
    wsel = 1'b0;
    base = 8'h00;
    s_next = s_reg;
    s_next.sync = {s_reg.sync[1:0], voice_reset_pin};
    if (s_reg.sync[1] == s_reg.sync[2])
      s_next.vrst_lvl = s_reg.sync[2];
    s_next.dl_on_d = voice_downlink_power_on;
    s_next.vrst_pulse = 1'b0;
    s_next.tx_valid = 1'b0;
    s_next.tx_bit = 1'b0;
    // control register writes
    if (wr_fire && reg_page == `CCRB_PAGE_ONE && reg_addr == `CCRB_ADDR_BB_CTRL)
      s_next.bb_ctrl = reg_wdata;
    if (wr_fire && reg_page == `CCRB_PAGE_ONE && reg_addr == `CCRB_ADDR_GAIN_CAL)
      s_next.i_gain = reg_wdata[3:0];
    if (wr_fire && reg_addr == `CCRB_ADDR_VOICE1)
      s_next.voice1 = reg_wdata;
    if (wr_fire && reg_page == `CCRB_PAGE_ONE && reg_addr == `CCRB_ADDR_VOICE2)
      s_next.voice2 = reg_wdata[2:0];
    for (int i = 0; i < 3; i++)
    begin
      if (wr_fire && reg_addr == `CCRB_ADDR_POP)
      begin
        s_next.pop[3*i+`CCRB_POP_AUTO] = reg_wdata[3*i+`CCRB_POP_AUTO];
        s_next.pop[3*i+`CCRB_POP_DIS] = reg_wdata[3*i+`CCRB_POP_DIS];
        if (!s_reg.pop[3*i+`CCRB_POP_AUTO])
          s_next.pop[3*i+`CCRB_POP_CHG] = reg_wdata[3*i+`CCRB_POP_CHG];
      end
      // auto charge: clear on enable, set on power rise, set wins
      if (s_reg.pop[3*i+`CCRB_POP_AUTO])
      begin
        if (out_en[i])
          s_next.pop[3*i+`CCRB_POP_CHG] = 1'b0;
        if (dl_rise)
          s_next.pop[3*i+`CCRB_POP_CHG] = 1'b1;
      end
    end
    // external voice reset also drops the sync enable
    if (vrst_rise && s_reg.voice1[`CCRB_V1_SYNC])
    begin
      s_next.vrst_pulse = 1'b1;
      s_next.voice1[`CCRB_V1_SYNC] = 1'b0;
    end
    // burst word drain into the buffers
    if (pop_fire)
    begin
      wsel = multislot ? s_reg.wr_ptr[4] : 1'b1;
      base = 8'(s_reg.wr_ptr[3:0]) * 8'd10;
      s_next.buf_bits[wsel][base +: `CCRB_WORD_W] = fifo_out_data;
      s_next.wr_ptr = multislot ? s_reg.wr_ptr + 5'h01 : {1'b0, s_reg.wr_ptr[3:0] + 4'h1};
    end
    case (s_reg.tx_state)
      CCRB_IDLE:
      begin
        if (start_ok)
        begin
          s_next.tx_state = CCRB_SEND;
          s_next.tx_cnt = 8'h00;
          s_next.tx_sel = multislot ? s_reg.alt_sel : 1'b1;
          s_next.alt_sel = multislot ? !s_reg.alt_sel : s_reg.alt_sel;
          s_next.wr_ptr = 5'h00;
        end
      end
      CCRB_SEND:
      begin
        s_next.tx_valid = 1'b1;
        s_next.tx_bit = s_reg.buf_bits[s_reg.tx_sel][s_reg.tx_cnt];
        if (s_reg.tx_cnt == `CCRB_LAST_BIT)
          s_next.tx_state = CCRB_IDLE;
        else
          s_next.tx_cnt = s_reg.tx_cnt + 8'h01;
      end
      default:
        s_next.tx_state = CCRB_IDLE;
    endcase
    // read port, write-only and unmapped read zero
    if (reg_rd)
    begin
      s_next.rdata = `CCRB_RESET_VALUE;
      if (reg_page == `CCRB_PAGE_ONE && reg_addr == `CCRB_ADDR_BB_CTRL)
        s_next.rdata = s_reg.bb_ctrl;
      if (reg_page == `CCRB_PAGE_ONE && reg_addr == `CCRB_ADDR_GAIN_CAL)
        s_next.rdata = {6'h00, s_reg.i_gain};
      if (reg_addr == `CCRB_ADDR_VOICE1)
        s_next.rdata = s_reg.voice1;
      if (reg_addr == `CCRB_ADDR_POP)
        s_next.rdata = {1'b0, s_reg.pop};
      if (reg_page == `CCRB_PAGE_ONE && reg_addr == `CCRB_ADDR_VOICE2)
        s_next.rdata = {7'h00, s_reg.voice2};
    end
    if (reset)
    begin
      s_next = '0;
      s_next.buf_bits = keep;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset || ce)
      s_reg <= s_next;
  end

  assign reg_rdata = s_reg.rdata;
  assign tx_bit = s_reg.tx_bit;
  assign tx_valid = s_reg.tx_valid;
  assign tx_busy = s_reg.tx_state == CCRB_SEND;
  assign gmsk_mode = !s_reg.bb_ctrl[`CCRB_BB_MOD_TYPE];
  assign baseband_loopback = s_reg.bb_ctrl[`CCRB_BB_LOOPBACK];
  assign calibration_select = s_reg.bb_ctrl[`CCRB_BB_EXT_CAL];
  assign output_level_index =
    ccrb_level_index(s_reg.bb_ctrl[`CCRB_BB_LEVEL_LO +: 3]);
  assign common_mode_index = ccrb_cm_index(s_reg.bb_ctrl[`CCRB_BB_CM_LO +: 3]);
  assign i_gain_calibration = $signed(s_reg.i_gain);
  assign voice_bypass = s_reg.voice1[`CCRB_V1_BYPASS];
  assign aux_input_gain_high = s_reg.voice1[`CCRB_V1_AUX_GAIN];
  assign voice_clock_continuous = s_reg.voice1[`CCRB_V1_CLK_MODE];
  assign voice_loopback = s_reg.voice1[`CCRB_V1_LOOPBACK];
  assign mic_bias_high = s_reg.voice1[`CCRB_V1_MIC_BIAS];
  assign microphone_input_selected =
    s_reg.voice1[`CCRB_V1_UL_SELECT] && voice_uplink_power_on;
  assign ear_amp_on = out_en[1] && voice_downlink_power_on &&
    !s_reg.voice1[`CCRB_V1_BUZZER];
  assign aux_amp_on = out_en[2] && voice_downlink_power_on &&
    !s_reg.voice1[`CCRB_V1_BUZZER];
  assign headset_amp_on = out_en[0] && voice_downlink_power_on;
  assign headset_mic_select = s_reg.voice2[`CCRB_V2_HS_MIC];
  assign headset_bias_select = s_reg.voice2[`CCRB_V2_HS_BIAS];
  assign voice_digital_reset = s_reg.vrst_pulse;

  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      capacitor_charge_on[i] = s_reg.pop[3*i+`CCRB_POP_CHG] && voice_downlink_power_on &&
        !out_en[i];
      capacitor_discharge_on[i] = s_reg.pop[3*i+`CCRB_POP_DIS] && voice_downlink_power_on &&
        !s_reg.pop[3*i+`CCRB_POP_CHG] && !out_en[i];
    end
  end

  AST_FIRST_BIT: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(tx_valid) |-> tx_bit == s_reg.buf_bits[s_reg.tx_sel][0])
    else $error("first burst bit is not bit zero");
  AST_BUF_HELD: assert property (@(posedge clk_sys) disable iff (reset)
    tx_busy |=> $stable(s_reg.buf_bits))
    else $error("burst buffer changed during transmission");
  AST_SINGLE_SLOT: assert property (@(posedge clk_sys) disable iff (reset)
    ce && start_ok && !multislot |=> s_reg.tx_sel && tx_busy)
    else $error("single slot did not pick buffer one");
  AST_ALTERNATE: assert property (@(posedge clk_sys) disable iff (reset)
    ce && start_ok && multislot |=> s_reg.tx_sel == $past(s_reg.alt_sel) &&
    s_reg.alt_sel != $past(s_reg.alt_sel))
    else $error("multislot did not alternate buffers");
  AST_VOICE_RESET: assert property (@(posedge clk_sys) disable iff (reset)
    ce && vrst_rise && s_reg.voice1[`CCRB_V1_SYNC] |=>
    voice_digital_reset && !s_reg.voice1[`CCRB_V1_SYNC])
    else $error("voice reset did not fire or clear enable");
  AST_NO_SYNC_RESET: assert property (@(posedge clk_sys) disable iff (reset)
    ce && !s_reg.voice1[`CCRB_V1_SYNC] |=> !voice_digital_reset)
    else $error("voice reset fired without enable");
  AST_MIC_POWER: assert property (@(posedge clk_sys) disable iff (reset)
    microphone_input_selected |-> voice_uplink_power_on && s_reg.voice1[`CCRB_V1_UL_SELECT])
    else $error("microphone selected without uplink power");
  AST_BUZZER: assert property (@(posedge clk_sys) disable iff (reset)
    s_reg.voice1[`CCRB_V1_BUZZER] |-> !ear_amp_on && !aux_amp_on)
    else $error("ear or aux stage on in buzzer mode");
  AST_DL_POWER: assert property (@(posedge clk_sys) disable iff (reset)
    !voice_downlink_power_on |-> !ear_amp_on && !aux_amp_on && !headset_amp_on)
    else $error("amplifier on without downlink power");
  AST_AUTO_CHARGE: assert property (@(posedge clk_sys) disable iff (reset)
    ce && dl_rise && s_reg.pop[`CCRB_POP_AUTO] |=> s_reg.pop[`CCRB_POP_CHG])
    else $error("auto charge not set on downlink power rise");
  AST_DISCHARGE: assert property (@(posedge clk_sys) disable iff (reset)
    capacitor_discharge_on[0] |-> !s_reg.pop[`CCRB_POP_CHG] && !out_en[0] &&
    voice_downlink_power_on)
    else $error("discharge active while inhibited");
  AST_READ_BACK: assert property (@(posedge clk_sys) disable iff (reset)
    ce && reg_wr && reg_page && reg_addr == `CCRB_ADDR_VOICE2 ##1 !reg_wr ##1
    ce && reg_rd && reg_page && reg_addr == `CCRB_ADDR_VOICE2 && !reg_wr |=>
    reg_rdata == {7'h00, $past(reg_wdata[2:0], 3)})
    else $error("second voice register read back wrong");
endmodule // ccrb_top

`default_nettype wire

// [ccrb_host.sv]
// host model driving the register port and collecting burst bits
`timescale 1ns/1ps
`default_nettype none
module ccrb_host (
  // clock
  input wire logic clk_sys,
  // register port
  output logic reg_page,
  output logic [4:0] reg_addr,
  output logic [9:0] reg_wdata,
  output logic reg_wr,
  input wire logic reg_wr_ready,
  output logic reg_rd,
  input wire logic [9:0] reg_rdata,
  // burst stream
  output logic burst_start,
  input wire logic tx_bit,
  input wire logic tx_valid
);
  logic [159:0] cap;
  int cap_cnt;
  initial
  begin
    {reg_page, reg_addr, reg_wdata, reg_wr, reg_rd, burst_start} = '0;
    cap_cnt = 0;
  end
  // request held until ready is seen high at a falling edge, dropped at the next rising edge
  task automatic write_reg(input logic pg, input logic [4:0] a, input logic [9:0] d);
    @(posedge clk_sys);
    reg_page <= pg;
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(negedge clk_sys);
    while (reg_wr_ready !== 1'b1)
      @(negedge clk_sys);
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
    @(negedge clk_sys);
  endtask
  task automatic read_reg(input logic pg, input logic [4:0] a, output logic [9:0] d);
    @(posedge clk_sys);
    reg_page <= pg;
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask
  // address shown without a write, to probe the ready line
  task automatic present(input logic pg, input logic [4:0] a);
    @(posedge clk_sys);
    reg_page <= pg;
    reg_addr <= a;
    @(negedge clk_sys);
  endtask
  task automatic start_burst();
    @(posedge clk_sys);
    cap = {160{1'bx}};
    cap_cnt = 0;
    burst_start <= 1'b1;
    @(posedge clk_sys);
    burst_start <= 1'b0;
  endtask
  // bits stored in arrival order
  always @(posedge clk_sys)
    if (tx_valid === 1'b1 && cap_cnt < 160)
    begin
      cap[cap_cnt] <= tx_bit;
      cap_cnt <= cap_cnt + 1;
    end
endmodule // ccrb_host
`default_nettype wire

// [ccrb_top_test.sv]
// self-checking bench for the codec control register bank
`timescale 1ns/1ps
`default_nettype none
module ccrb_top_test;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic dl_on = 1'b0;
  logic ul_on = 1'b0;
  logic vrst_pin = 1'b0;
  logic reg_page, reg_wr, reg_wr_ready, reg_rd, burst_start, tx_bit, tx_valid, tx_busy;
  logic [4:0] reg_addr;
  logic [9:0] reg_wdata, reg_rdata;
  logic gmsk_mode, baseband_loopback, calibration_select, voice_bypass, aux_input_gain_high;
  logic voice_clock_continuous, voice_loopback, mic_bias_high, microphone_input_selected;
  logic ear_amp_on, aux_amp_on, headset_amp_on, headset_mic_select, headset_bias_select;
  logic voice_digital_reset;
  logic [2:0] output_level_index, common_mode_index, capacitor_charge_on, capacitor_discharge_on;
  logic signed [3:0] i_gain_calibration;
  logic [7:0] voice_vec;
  logic [8:0] bb_vec, e;
  logic [2:0] k;
  int fails = 0;
  int check_count = 0;
  int n;
  assign voice_vec = {voice_bypass, aux_input_gain_high, voice_clock_continuous, voice_loopback,
    mic_bias_high, microphone_input_selected, ear_amp_on, aux_amp_on};
  assign bb_vec = {calibration_select, gmsk_mode, baseband_loopback, output_level_index,
    common_mode_index};
  always #25 clk_sys = ~clk_sys;

  ccrb_top #(.FIFO_DEPTH(32)) i_ccrb_top (
    .clk_sys(clk_sys), .reset(reset), .ce(ce), .reg_page(reg_page), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_wr_ready(reg_wr_ready), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .voice_downlink_power_on(dl_on), .voice_uplink_power_on(ul_on),
    .burst_start(burst_start), .tx_bit(tx_bit), .tx_valid(tx_valid), .tx_busy(tx_busy),
    .gmsk_mode(gmsk_mode), .baseband_loopback(baseband_loopback),
    .calibration_select(calibration_select), .output_level_index(output_level_index),
    .common_mode_index(common_mode_index), .i_gain_calibration(i_gain_calibration),
    .voice_bypass(voice_bypass), .aux_input_gain_high(aux_input_gain_high),
    .voice_clock_continuous(voice_clock_continuous), .voice_loopback(voice_loopback),
    .mic_bias_high(mic_bias_high), .microphone_input_selected(microphone_input_selected),
    .ear_amp_on(ear_amp_on), .aux_amp_on(aux_amp_on), .headset_amp_on(headset_amp_on),
    .headset_mic_select(headset_mic_select), .headset_bias_select(headset_bias_select),
    .capacitor_charge_on(capacitor_charge_on), .capacitor_discharge_on(capacitor_discharge_on),
    .voice_reset_pin(vrst_pin), .voice_digital_reset(voice_digital_reset));

  ccrb_host i_ccrb_host (
    .clk_sys(clk_sys), .reg_page(reg_page), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_wr_ready(reg_wr_ready), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .burst_start(burst_start), .tx_bit(tx_bit), .tx_valid(tx_valid));

  task automatic check(input string what, input logic [159:0] exp, input logic [159:0] got);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_reg(input string what, input logic pg, input logic [4:0] a,
    input logic [9:0] exp);
    logic [9:0] d;
    i_ccrb_host.read_reg(pg, a, d);
    check(what, exp, d);
  endtask
  task automatic set_pw(input logic dl, input logic ul);
    @(posedge clk_sys);
    dl_on <= dl;
    ul_on <= ul;
    @(negedge clk_sys);
  endtask
  task automatic do_reset();
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
  endtask
  function automatic logic [9:0] wd(input logic [9:0] base, input int i);
    wd = base ^ 10'(i * 37);
  endfunction
  function automatic logic [159:0] pk(input logic [9:0] base);
    for (int i = 0; i < 16; i++)
      pk[10*i +: 10] = wd(base, i);
  endfunction
  task automatic fill(input logic [9:0] base);
    for (int i = 0; i < 16; i++)
      i_ccrb_host.write_reg(1'b0, 5'h03, wd(base, i));
  endtask
  task automatic wait_idle();
    @(negedge clk_sys);
    while (tx_busy === 1'b1)
      @(negedge clk_sys);
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic run_burst(input logic [159:0] exp);
    i_ccrb_host.start_burst();
    wait_idle();
    check("burst length", 160, i_ccrb_host.cap_cnt);
    check("burst bits", exp, i_ccrb_host.cap);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    $display("ERROR watchdog expected finish seen timeout");
    report_and_stop();
  end

  initial
  begin
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    chk_reg("bb ctrl rst", 1'b1, 5'h06, 10'h000);
    chk_reg("voice1 rst", 1'b0, 5'h08, 10'h000);
    chk_reg("pop rst", 1'b0, 5'h0a, 10'h000);
    chk_reg("voice2 rst", 1'b1, 5'h0b, 10'h000);
    check("gmsk rst", 1'b1, gmsk_mode);
    for (int i = 0; i < 8; i++)
    begin
      k = i[2:0];
      e = {k[0], ~k[1], k[2], (k[2] ? {2'b10, k[1]} : k), (k[2] ? 3'h4 : k)};
      i_ccrb_host.write_reg(1'b1, 5'h06, {k[0], k, 1'b0, k[1], k[2], k});
      check("bb decode", e, bb_vec);
      chk_reg("bb ctrl", 1'b1, 5'h06, {k[0], k, 1'b0, k[1], k[2], k});
    end
    i_ccrb_host.write_reg(1'b0, 5'h06, 10'h155);
    chk_reg("bb ctrl page", 1'b1, 5'h06, 10'h3df);
    i_ccrb_host.write_reg(1'b1, 5'h0e, 10'h3ff);
    chk_reg("gain cal", 1'b1, 5'h0e, 10'h00f);
    check("gain neg", 1'b1, i_gain_calibration < 0);
    i_ccrb_host.write_reg(1'b1, 5'h0e, 10'h001);
    check("gain pos", 4'h1, i_gain_calibration);
    i_ccrb_host.write_reg(1'b0, 5'h1f, 10'h3ff);
    chk_reg("unmapped", 1'b0, 5'h1f, 10'h000);
    chk_reg("write only", 1'b0, 5'h03, 10'h000);
    $display("test baseband registers done");
    set_pw(1'b1, 1'b0);
    i_ccrb_host.write_reg(1'b0, 5'h08, 10'h3ff);
    check("voice1 a", 8'hf8, voice_vec);
    chk_reg("voice1", 1'b0, 5'h08, 10'h3ff);
    set_pw(1'b1, 1'b1);
    check("voice1 b", 8'hfc, voice_vec);
    i_ccrb_host.write_reg(1'b1, 5'h08, 10'h00b);
    check("voice1 c", 8'h07, voice_vec);
    set_pw(1'b0, 1'b1);
    check("voice1 d", 8'h04, voice_vec);
    i_ccrb_host.write_reg(1'b0, 5'h08, 10'h000);
    check("voice1 e", 8'h00, voice_vec);
    i_ccrb_host.write_reg(1'b1, 5'h0b, 10'h3ff);
    chk_reg("voice2", 1'b1, 5'h0b, 10'h007);
    check("voice2 sel", 3'b110,
      {headset_mic_select, headset_bias_select, headset_amp_on});
    @(posedge clk_sys);
    ce <= 1'b0;
    i_ccrb_host.write_reg(1'b1, 5'h0b, 10'h000);
    @(posedge clk_sys);
    ce <= 1'b1;
    chk_reg("ce freeze", 1'b1, 5'h0b, 10'h007);
    set_pw(1'b1, 1'b0);
    check("headset amp", 1'b1, headset_amp_on);
    i_ccrb_host.write_reg(1'b1, 5'h0b, 10'h000);
    i_ccrb_host.write_reg(1'b0, 5'h08, 10'h080);
    @(posedge clk_sys);
    vrst_pin <= 1'b1;
    n = 0;
    @(negedge clk_sys);
    while (voice_digital_reset !== 1'b1 && n < 12)
    begin
      @(negedge clk_sys);
      n++;
    end
    check("voice reset pulse", 1'b1, voice_digital_reset);
    @(posedge clk_sys);
    vrst_pin <= 1'b0;
    chk_reg("sync cleared", 1'b0, 5'h08, 10'h000);
    $display("test voice registers done");
    set_pw(1'b0, 1'b0);
    i_ccrb_host.write_reg(1'b0, 5'h0a, 10'h249);
    chk_reg("pop reserved", 1'b0, 5'h0a, 10'h049);
    i_ccrb_host.write_reg(1'b0, 5'h0a, 10'h004);
    set_pw(1'b1, 1'b0);
    chk_reg("auto charge", 1'b0, 5'h0a, 10'h006);
    i_ccrb_host.write_reg(1'b0, 5'h0a, 10'h004);
    chk_reg("auto write", 1'b0, 5'h0a, 10'h006);
    check("charge on", 3'b001, capacitor_charge_on);
    i_ccrb_host.write_reg(1'b1, 5'h0b, 10'h002);
    chk_reg("auto clear", 1'b0, 5'h0a, 10'h004);
    i_ccrb_host.write_reg(1'b0, 5'h0a, 10'h001);
    check("dis with enable", 3'b000, capacitor_discharge_on);
    i_ccrb_host.write_reg(1'b1, 5'h0b, 10'h000);
    check("dis on", 3'b001, capacitor_discharge_on);
    i_ccrb_host.write_reg(1'b0, 5'h0a, 10'h003);
    check("dis with charge", 3'b000, capacitor_discharge_on);
    set_pw(1'b0, 1'b0);
    check("dis power off", 3'b000, capacitor_discharge_on);
    $display("test pop reduction done");
    fill(10'h2a5);
    repeat (4) @(posedge clk_sys);
    run_burst(pk(10'h2a5));
    run_burst(pk(10'h2a5));
    do_reset();
    run_burst(pk(10'h2a5));
    $display("test single slot done");
    do_reset();
    i_ccrb_host.write_reg(1'b1, 5'h06, 10'h020);
    fill(10'h1c3);
    i_ccrb_host.start_burst();
    fill(10'h1c3);
    fill(10'h0e7);
    i_ccrb_host.present(1'b0, 5'h03);
    check("fifo full", 2'b01, {reg_wr_ready, tx_busy});
    wait_idle();
    check("slot zero bits", pk(10'h1c3), i_ccrb_host.cap);
    repeat (40) @(posedge clk_sys);
    @(negedge clk_sys);
    check("fifo drained", 1'b1, reg_wr_ready);
    run_burst(pk(10'h0e7));
    run_burst(pk(10'h1c3));
    $display("test multislot done");
    report_and_stop();
  end
endmodule // ccrb_top_test
`default_nettype wire
